// ===== logic/ssb_config.sv
`timescale 1ns/1ps
// How it works
// - 11-bit start time, split high/low, resets 5
// - 12-bit hold time, split high/low, resets 2
// - spread control resets 0x07; bit7 bypasses spreading
// - size code picks 16, 24, 32 or any
// - bit 2 enables differential coding
// - decoder clock 4, 2, 1, 0.5 MHz
// - receive demod clock full, half, quarter
// - acquisition demod clock uses same encoding
// - timing fields act only in frequency mode
// - timing tick 450 kHz or 4 MHz
module ssb_config
   import ssb_pkg::*;
(
   // clock, reset, freeze
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic ce,
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [8:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // baseband status, same clock
   input wire logic rx_active,
   input wire logic symbol_edge,
   // spread path controls
   output logic spreading_bypass,
   output logic [1:0] payload_size_select,
   output logic [7:0] payload_bytes,
   output logic differential_coding_on,
   output logic forward_correction_on,
   output logic spreading_unit_on,
   // clock enables and deviation
   output logic decoder_clk_en,
   output logic demod_clk_en,
   output logic deviation_active
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // payload size code to byte count, zero means arbitrary
   function automatic logic [7:0] payload_of(input logic [1:0] code);
      case (code)
         2'b00: payload_of = PAYLOAD_16;
         2'b01: payload_of = PAYLOAD_24;
         2'b10: payload_of = PAYLOAD_32;
         default: payload_of = PAYLOAD_ANY;
      endcase
   endfunction

   // demod clock code to master clock divisor; 11 falls back to full rate
   function automatic logic [9:0] demod_div_of(input logic [1:0] code);
      case (code)
         2'b01: demod_div_of = 10'h002;
         2'b10: demod_div_of = 10'h004;
         default: demod_div_of = 10'h001;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   logic [7:0] control_reg; // spread control, reserved bits kept zero
   logic [7:0] mode_clocks_reg; // decoder and demod clock choices
   logic phase_mode_reg; // 1 selects frequency control system
   logic timing_clk_reg; // 1 selects the 4 MHz timing tick
   logic [10:0] start_reg; // deviation start time
   logic [11:0] hold_reg; // deviation hold time
   logic [7:0] payload_reg; // decoded payload size
   logic [9:0] demod_div; // divisor chosen by receive state
   logic [9:0] decoder_div; // divisor for the decoder clock
   logic [9:0] timing_div; // divisor for the timing tick
   logic timing_tick; // tick that paces the deviation timer
   logic dev_waiting; // timer counting the start time
   logic [7:0] read_byte; // read mux output
   logic [6:0] idx; // register index from the byte address
   logic req_take; // new bus request taken this edge
   logic wr_take; // write with low byte lane enabled

   assign idx = wb_adr_i[8:2];
   // a request is taken once; ack high blocks a second take
   assign req_take = ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_take = req_take && wb_we_i && wb_sel_i[0];

   // ----------------------------------------------------------------
   // bus slave handshake
   // ----------------------------------------------------------------
   // ack one cycle after the take; unmapped indexes are acked, read zero
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (ce) begin
         wb_ack_o <= req_take;
         if (req_take && !wb_we_i) begin
            wb_dat_o <= {24'h00_0000, read_byte};
         end
      end
   end

   // read mux; unused upper bits of the narrow registers are forced to zero here
   always_comb begin
      case (idx)
         IDX_SPREAD_CONTROL: read_byte = control_reg;
         IDX_SPREAD_MODE_CLOCKS: read_byte = mode_clocks_reg;
         IDX_BLOCK_STATUS: read_byte = {6'h00, dev_waiting, deviation_active};
         IDX_PHASE_MODE: read_byte = {6'h00, timing_clk_reg, phase_mode_reg};
         IDX_DEV_START_HIGH: read_byte = {5'h00, start_reg[10:8]};
         IDX_DEV_START_LOW: read_byte = start_reg[7:0];
         IDX_DEV_HOLD_HIGH: read_byte = {4'h0, hold_reg[11:8]};
         IDX_DEV_HOLD_LOW: read_byte = hold_reg[7:0];
         default: read_byte = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // spread control and mode clocks
   // ----------------------------------------------------------------
   // bits 6 and 3 are never stored so they stay zero
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         control_reg <= RST_SPREAD_CONTROL;
      end else if (wr_take && idx == IDX_SPREAD_CONTROL) begin
         control_reg <= wb_dat_i[7:0] & 8'hb7;
      end
   end

   // mode clocks is fully writable, its reserved pair included
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         mode_clocks_reg <= RST_SPREAD_MODE_CLOCKS;
      end else if (wr_take && idx == IDX_SPREAD_MODE_CLOCKS) begin
         mode_clocks_reg <= wb_dat_i[7:0];
      end
   end

   // phase mode and timing clock select
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         phase_mode_reg <= RST_PHASE_MODE[BIT_PHASE_MODE];
         timing_clk_reg <= RST_PHASE_MODE[BIT_TIMING_CLK];
      end else if (wr_take && idx == IDX_PHASE_MODE) begin
         phase_mode_reg <= wb_dat_i[BIT_PHASE_MODE];
         timing_clk_reg <= wb_dat_i[BIT_TIMING_CLK];
      end
   end

   // ----------------------------------------------------------------
   // deviation timing fields
   // ----------------------------------------------------------------
   // the halves are written separately; software should write both
   // before the next symbol edge or the timer sees a mixed value
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         start_reg <= RST_DEV_START;
      end else if (wr_take && idx == IDX_DEV_START_HIGH) begin
         start_reg[10:8] <= wb_dat_i[2:0];
      end else if (wr_take && idx == IDX_DEV_START_LOW) begin
         start_reg[7:0] <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         hold_reg <= RST_DEV_HOLD;
      end else if (wr_take && idx == IDX_DEV_HOLD_HIGH) begin
         hold_reg[11:8] <= wb_dat_i[3:0];
      end else if (wr_take && idx == IDX_DEV_HOLD_LOW) begin
         hold_reg[7:0] <= wb_dat_i[7:0];
      end
   end

   // ----------------------------------------------------------------
   // control outputs
   // ----------------------------------------------------------------
   assign spreading_bypass = control_reg[BIT_BYPASS];
   assign payload_size_select = control_reg[BIT_SIZE_HI:BIT_SIZE_LO];
   assign differential_coding_on = control_reg[BIT_DIFF];
   assign forward_correction_on = control_reg[BIT_FEC];
   assign spreading_unit_on = control_reg[BIT_UNIT];
   assign payload_bytes = payload_reg;

   // payload decode registered so the byte count comes from a flop
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         payload_reg <= PAYLOAD_16;
      end else if (ce) begin
         payload_reg <= payload_of(control_reg[BIT_SIZE_HI:BIT_SIZE_LO]);
      end
   end

   // ----------------------------------------------------------------
   // clock enables and deviation timer
   // ----------------------------------------------------------------
   // receive field while data flows, acquisition field otherwise
   assign demod_div = rx_active ? demod_div_of(mode_clocks_reg[3:2])
                                : demod_div_of(mode_clocks_reg[1:0]);
   assign decoder_div = DIV_FAST << mode_clocks_reg[7:6];
   assign timing_div = timing_clk_reg ? DIV_FAST : DIV_SLOW;

   ssb_rate_div u_decoder_div (
      .mclk(mclk),
      .reset_n(reset_n),
      .ce(ce),
      .divisor(decoder_div),
      .tick(decoder_clk_en)
   );

   ssb_rate_div u_demod_div (
      .mclk(mclk),
      .reset_n(reset_n),
      .ce(ce),
      .divisor(demod_div),
      .tick(demod_clk_en)
   );

   ssb_rate_div u_timing_div (
      .mclk(mclk),
      .reset_n(reset_n),
      .ce(ce),
      .divisor(timing_div),
      .tick(timing_tick)
   );

   // selector system leaves the timer idle, fields unused
   ssb_dev_timer u_dev_timer (
      .mclk(mclk),
      .reset_n(reset_n),
      .ce(ce),
      .tick(timing_tick),
      .trigger(symbol_edge),
      .enable(phase_mode_reg),
      .start_time(start_reg),
      .hold_time(hold_reg),
      .active(deviation_active),
      .waiting(dev_waiting)
   );

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);

   sequence s_take;
      ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence

   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   chk_ack_after_take: assert property (s_take |=> s_ack_pulse)
      else $error("ack did not follow a taken request for one cycle");

   chk_start_high_zero: assert property (
      $past(req_take && !wb_we_i && idx == IDX_DEV_START_HIGH) && wb_ack_o
      |-> wb_dat_o[7:3] == 5'h00)
      else $error("reserved start high bits read nonzero");

   chk_spread_reset: assert property (
      $past(!reset_n) |-> control_reg == RST_SPREAD_CONTROL && start_reg == RST_DEV_START
      && hold_reg == RST_DEV_HOLD)
      else $error("config not at reset value after reset");

   chk_payload_decode: assert property (
      ce |=> payload_bytes == payload_of($past(payload_size_select)))
      else $error("payload bytes do not match size code");

   chk_diff_write: assert property (
      wr_take && idx == IDX_SPREAD_CONTROL
      |=> differential_coding_on == $past(wb_dat_i[BIT_DIFF]))
      else $error("differential coding bit not written");

   chk_hold_write: assert property (
      wr_take && idx == IDX_DEV_HOLD_HIGH
      |=> hold_reg[11:8] == $past(wb_dat_i[3:0]) && $stable(hold_reg[7:0]))
      else $error("hold high write wrong");

   chk_decoder_rate: assert property (
      decoder_div == 10'(50 << mode_clocks_reg[7:6]))
      else $error("decoder divisor wrong");

   chk_demod_select: assert property (
      rx_active && mode_clocks_reg[3:2] == 2'b10 |-> demod_div == 10'h004)
      else $error("receive demod divisor wrong");

   chk_acquire_select: assert property (
      !rx_active && mode_clocks_reg[1:0] == 2'b11 |-> demod_div == 10'h001)
      else $error("acquisition demod divisor wrong");

   chk_mode_gates_dev: assert property (
      (!phase_mode_reg && ce) [*2] |-> !deviation_active && !dev_waiting)
      else $error("deviation runs in selector mode");

   chk_timing_clock: assert property (
      timing_div == (timing_clk_reg ? 10'd50 : 10'd444))
      else $error("timing tick divisor wrong");
endmodule

// ===== logic/ssb_pkg.sv
// ----------------------------------------------------------------
// shared constants of the spread-spectrum and bpsk config block
// ----------------------------------------------------------------
package ssb_pkg;
   // register indexes; byte address on the bus is four times these
   localparam logic [6:0] IDX_SPREAD_CONTROL = 7'h01;
   localparam logic [6:0] IDX_SPREAD_MODE_CLOCKS = 7'h02;
   localparam logic [6:0] IDX_BLOCK_STATUS = 7'h70;
   localparam logic [6:0] IDX_PHASE_MODE = 7'h7b;
   localparam logic [6:0] IDX_DEV_START_HIGH = 7'h7c;
   localparam logic [6:0] IDX_DEV_START_LOW = 7'h7d;
   localparam logic [6:0] IDX_DEV_HOLD_HIGH = 7'h7e;
   localparam logic [6:0] IDX_DEV_HOLD_LOW = 7'h7f;

   // spread control field positions
   localparam int BIT_BYPASS = 7;
   localparam int BIT_SIZE_HI = 5;
   localparam int BIT_SIZE_LO = 4;
   localparam int BIT_DIFF = 2;
   localparam int BIT_FEC = 1;
   localparam int BIT_UNIT = 0;
   // phase mode register field positions
   localparam int BIT_TIMING_CLK = 1;
   localparam int BIT_PHASE_MODE = 0;

   // reset values
   localparam logic [7:0] RST_SPREAD_CONTROL = 8'h07;
   localparam logic [7:0] RST_SPREAD_MODE_CLOCKS = 8'h65;
   localparam logic [7:0] RST_PHASE_MODE = 8'h02;
   localparam logic [10:0] RST_DEV_START = 11'h005;
   localparam logic [11:0] RST_DEV_HOLD = 12'h002;

   // payload sizes in bytes for the fixed size codes
   localparam logic [7:0] PAYLOAD_16 = 8'h10;
   localparam logic [7:0] PAYLOAD_24 = 8'h18;
   localparam logic [7:0] PAYLOAD_32 = 8'h20;
   localparam logic [7:0] PAYLOAD_ANY = 8'h00;

   // timing: master clock and derived tick divisors
   localparam int MCLK_HZ = 200_000_000;
   localparam int FAST_TICK_HZ = 4_000_000;
   localparam int SLOW_TICK_HZ = 450_000;
   localparam logic [9:0] DIV_FAST = 10'(MCLK_HZ / FAST_TICK_HZ);
   localparam logic [9:0] DIV_SLOW = 10'(MCLK_HZ / SLOW_TICK_HZ);
endpackage

// ===== logic/ssb_rate_div.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// rate divider: one-cycle tick every divisor master clocks
// ----------------------------------------------------------------
module ssb_rate_div
   import ssb_pkg::*;
(
   // clock, reset, freeze
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic ce,
   // divisor, 1 gives a tick every cycle
   input wire logic [9:0] divisor,
   // tick out
   output logic tick
);
   logic [9:0] cnt_reg; // cycles since last tick

   // a changed divisor takes effect at once: a larger one stretches the current period, a smaller one can end it early
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         cnt_reg <= 10'h000;
         tick <= 1'b0;
      end else if (ce) begin
         if (cnt_reg + 10'h001 >= divisor) begin
            cnt_reg <= 10'h000;
            tick <= 1'b1;
         end else begin
            cnt_reg <= cnt_reg + 10'h001;
            tick <= 1'b0;
         end
      end
   end
endmodule

// ===== logic/ssb_dev_timer.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// deviation timer: wait start ticks, then hold deviation hold ticks
// ----------------------------------------------------------------
module ssb_dev_timer
   import ssb_pkg::*;
(
   // clock, reset, freeze
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic ce,
   // timing base and symbol edge
   input wire logic tick,
   input wire logic trigger,
   input wire logic enable,
   // programmed times in ticks
   input wire logic [10:0] start_time,
   input wire logic [11:0] hold_time,
   // state out
   output logic active,
   output logic waiting
);
   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_HOLD} ssb_dev_state_t;

   ssb_dev_state_t state_reg; // current phase
   logic [11:0] cnt_reg; // ticks counted in the phase

   // edges arriving while busy are dropped; a restart mid-hold would
   // chop the deviation pulse and upset the carrier phase
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 12'h000;
      end else if (ce) begin
         if (!enable) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 12'h000;
         end else begin
            case (state_reg)
               ST_IDLE: begin
                  if (trigger) begin
                     state_reg <= ST_START;
                     cnt_reg <= 12'h000;
                  end
               end
               ST_START: begin
                  if (tick) begin
                     if (cnt_reg >= {1'b0, start_time}) begin
                        state_reg <= ST_HOLD;
                        cnt_reg <= 12'h000;
                     end else begin
                        cnt_reg <= cnt_reg + 12'h001;
                     end
                  end
               end
               ST_HOLD: begin
                  if (tick) begin
                     if (cnt_reg + 12'h001 >= hold_time) begin
                        state_reg <= ST_IDLE;
                        cnt_reg <= 12'h000;
                     end else begin
                        cnt_reg <= cnt_reg + 12'h001;
                     end
                  end
               end
               default: begin
                  state_reg <= ST_IDLE;
                  cnt_reg <= 12'h000;
               end
            endcase
         end
      end
   end

   // outputs straight from the state flops
   assign active = (state_reg == ST_HOLD);
   assign waiting = (state_reg == ST_START);
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// compare helper: counts every check, reports a mismatch at once
// ----------------------------------------------------------------
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin errors++; \
   $display("BAD %0t got %0h expected %0h", $time, got, exp); end end
module tb_top
   import ssb_pkg::*;
;
   // clock, reset, freeze
   logic mclk, reset_n, ce;
   // bus master side
   logic wb_cyc_i, wb_stb_i, wb_we_i;
   logic [8:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic wb_ack_o;
   // baseband status and block outputs
   logic rx_active, symbol_edge, spreading_bypass, differential_coding_on;
   logic forward_correction_on, spreading_unit_on, decoder_clk_en, demod_clk_en;
   logic deviation_active;
   logic [1:0] payload_size_select;
   logic [7:0] payload_bytes;
   // bench bookkeeping
   int errors = 0, n_tests = 0, cycles = 0;
   logic [31:0] rnd = 32'hf750, q;
   logic [6:0] tbl [6] = '{IDX_SPREAD_CONTROL, IDX_SPREAD_MODE_CLOCKS, IDX_DEV_START_HIGH,
      IDX_DEV_START_LOW, IDX_DEV_HOLD_HIGH, IDX_DEV_HOLD_LOW};
   logic [7:0] msk [6] = '{8'hb7, 8'hff, 8'h07, 8'hff, 8'h0f, 8'hff};
   logic [7:0] mir [6] = '{8'h07, 8'h65, 8'h00, 8'h05, 8'h00, 8'h02};

   ssb_config dut (.mclk(mclk), .reset_n(reset_n), .ce(ce), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_active(rx_active),
      .symbol_edge(symbol_edge), .spreading_bypass(spreading_bypass),
      .payload_size_select(payload_size_select), .payload_bytes(payload_bytes),
      .differential_coding_on(differential_coding_on),
      .forward_correction_on(forward_correction_on), .spreading_unit_on(spreading_unit_on),
      .decoder_clk_en(decoder_clk_en), .demod_clk_en(demod_clk_en),
      .deviation_active(deviation_active));

   // ----------------------------------------------------------------
   // clock and hang guard
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // ceiling sits well above the longest expected run
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 30000) begin
         errors++;
         conclude();
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // payload size in bytes for a size code
   function automatic logic [7:0] pay(input logic [1:0] c);
      return (c == 2'b00) ? 8'h10 : (c == 2'b01) ? 8'h18 : (c == 2'b10) ? 8'h20 : 8'h00;
   endfunction
   // demod enable period for a clock code; code 11 runs at the master rate
   function automatic int dmp(input logic [1:0] c);
      return (c == 2'b01) ? 2 : (c == 2'b10) ? 4 : 1;
   endfunction
   // one classic cycle; the upper data bits carry noise the block must ignore
   task automatic wb_io(input logic we, input logic [6:0] idx, input logic [7:0] d,
      input logic [3:0] sel, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge mclk);
      rnd = lfsr(rnd);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= sel;
      wb_dat_i <= {rnd[23:0], d};
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 50) begin
         errors++;
         $display("BAD %0t no bus answer", $time);
      end
   endtask
   // control outputs against a control byte, one settled cycle later
   task automatic chk_ctrl(input logic [7:0] c);
      @(posedge mclk);
      #1;
      `CHK({spreading_bypass, payload_size_select, differential_coding_on,
         forward_correction_on, spreading_unit_on}, {c[7], c[5:4], c[2:0]})
      `CHK(payload_bytes, pay(c[5:4]))
   endtask
   // cycles between two enable pulses of the chosen output
   task automatic period(input bit dec, output int p);
      int n;
      n = 0;
      p = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while ((dec ? decoder_clk_en : demod_clk_en) !== 1'b1 && n < 1000);
      do begin
         @(posedge mclk);
         #1;
         p++;
      end while ((dec ? decoder_clk_en : demod_clk_en) !== 1'b1 && p < 1000);
   endtask
   // program and fire one deviation sequence, then time both phases
   task automatic run_tmr(input logic [7:0] pm, input logic [10:0] s, input logic [11:0] h,
      input int tick);
      time t0;
      int d, a;
      a = 0;
      wb_io(1, IDX_PHASE_MODE, pm, 4'hf, q);
      wb_io(1, IDX_DEV_START_HIGH, {5'h00, s[10:8]}, 4'hf, q);
      wb_io(1, IDX_DEV_START_LOW, s[7:0], 4'hf, q);
      wb_io(1, IDX_DEV_HOLD_HIGH, {4'h0, h[11:8]}, 4'hf, q);
      wb_io(1, IDX_DEV_HOLD_LOW, h[7:0], 4'hf, q);
      @(posedge mclk);
      symbol_edge <= 1'b1;
      @(posedge mclk);
      symbol_edge <= 1'b0;
      t0 = $time;
      wb_io(0, IDX_BLOCK_STATUS, 8'h00, 4'hf, q);
      `CHK(q, 32'h0000_0002)
      while (deviation_active !== 1'b1 && ($time - t0) < 100000) begin
         @(posedge mclk);
         #1;
      end
      d = int'(($time - t0) / 5);
      `CHK(d >= s * tick && d <= (s + 1) * tick + 3, 1'b1)
      while (deviation_active === 1'b1 && a < 20000) begin
         @(posedge mclk);
         #1;
         a++;
      end
      `CHK(a >= h * tick - 1 && a <= h * tick + 1, 1'b1)
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      int p, k;
      logic [7:0] v;
      reset_n = 1'b0;
      ce = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 9'h000;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0000_0000;
      rx_active = 1'b0;
      symbol_edge = 1'b0;
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      // reset values of every writable register
      for (k = 0; k < 6; k++) begin
         wb_io(0, tbl[k], 8'h00, 4'hf, q);
         `CHK(q, {24'h00_0000, mir[k]})
      end
      wb_io(0, IDX_PHASE_MODE, 8'h00, 4'hf, q);
      `CHK(q, 32'h0000_0002)
      chk_ctrl(8'h07);
      // unmapped place takes no write and reads zero
      wb_io(1, 7'h10, 8'hff, 4'hf, q);
      wb_io(0, 7'h10, 8'h00, 4'hf, q);
      `CHK(q, 32'h0000_0000)
      // low byte not enabled: write must leave control alone
      wb_io(1, IDX_SPREAD_CONTROL, 8'hf0, 4'he, q);
      chk_ctrl(8'h07);
      // random writes with read-back through the reserved-bit masks
      for (k = 0; k < 24; k++) begin
         rnd = lfsr(rnd);
         p = int'(rnd[10:8]) % 6;
         // wb_io steps rnd itself, so the written byte is kept aside first
         v = rnd[7:0];
         // arbitrary length never goes out with correction still on
         if (p == 0 && v[5:4] == 2'b11) v[1] = 1'b0;
         wb_io(1, tbl[p], v, 4'hf, q);
         mir[p] = v & msk[p];
         if (p == 0) chk_ctrl(mir[0]);
         p = int'(rnd[14:12]) % 6;
         wb_io(0, tbl[p], 8'h00, 4'hf, q);
         `CHK(q, {24'h00_0000, mir[p]})
      end
      // every size code, bypass set and correction cleared on the arbitrary one
      // no packet length, auto transmit or transmit-on is driven here
      for (k = 0; k < 4; k++) begin
         v = {k[1] & k[0], 1'b0, k[1:0], 2'b01, ~(k[1] & k[0]), 1'b1};
         wb_io(1, IDX_SPREAD_CONTROL, v, 4'hf, q);
         chk_ctrl(v);
      end
      // decoder enable period per code
      for (k = 0; k < 4; k++) begin
         wb_io(1, IDX_SPREAD_MODE_CLOCKS, {k[1:0], 6'h25}, 4'hf, q);
         period(1, p);
         `CHK(p, 50 << k)
      end
      // demod enable follows the field that matches the receive state
      for (k = 0; k < 8; k++) begin
         v[1:0] = (k[1:0] == 2'b10) ? 2'b00 : 2'b10;
         @(posedge mclk);
         rx_active <= k[2];
         wb_io(1, IDX_SPREAD_MODE_CLOCKS, k[2] ? {4'h6, k[1:0], v[1:0]} :
            {4'h6, v[1:0], k[1:0]}, 4'hf, q);
         period(0, p);
         `CHK(p, dmp(k[1:0]))
      end
      // deviation timing on both tick rates
      run_tmr(8'h03, 11'h002, 12'h003, int'(DIV_FAST));
      // start of one tick: a zero start could end before the status read
      run_tmr(8'h01, 11'h001, 12'h001, int'(DIV_SLOW));
      // selector system: a symbol edge must start nothing
      wb_io(1, IDX_PHASE_MODE, 8'h02, 4'hf, q);
      @(posedge mclk);
      symbol_edge <= 1'b1;
      @(posedge mclk);
      symbol_edge <= 1'b0;
      p = 0;
      repeat (400) begin
         @(posedge mclk);
         #1;
         if (deviation_active !== 1'b0) p++;
      end
      `CHK(p, 0)
      // frozen block takes nothing; the held request is answered once ce returns
      @(posedge mclk);
      ce <= 1'b0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= 1'b1;
      wb_adr_i <= {IDX_SPREAD_CONTROL, 2'b00};
      wb_sel_i <= 4'hf;
      wb_dat_i <= 32'h0000_0001;
      p = 0;
      repeat (20) begin
         @(posedge mclk);
         if (wb_ack_o !== 1'b0 || spreading_bypass !== 1'b1) p++;
      end
      `CHK(p, 0)
      ce <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      `CHK(wb_ack_o, 1'b1)
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      chk_ctrl(8'h01);
      conclude();
   end
endmodule
